// ### include/cbm_pkg.sv
// Shared types and constants of the circular buffer mode one engine.
package cbm_pkg;
   localparam int DATA_W = 16;
   localparam int RAM_AW = 13;
   // Descriptor word offsets from the block base N.
   localparam logic [1:0] DESC_CTL = 2'h0;
   localparam logic [1:0] DESC_START = 2'h1;
   localparam logic [1:0] DESC_CUR = 2'h2;
   localparam logic [1:0] DESC_END = 2'h3;
   // Record layout at the current pointer.
   localparam logic [RAM_AW-1:0] REC_TTAG_OFS = 13'h0001;
   localparam logic [RAM_AW-1:0] REC_DATA_OFS = 13'h0002;
   // Control word fields.
   localparam int CTL_PINGPONG_BIT = 0;
   localparam int CTL_CIRC1_BIT = 1;
   localparam int CTL_CIRC2_BIT = 2;
   localparam int CTL_WRAP_IRQ_BIT = 15;
   // Command word fields.
   localparam logic [4:0] BROADCAST_FLAG_RT = 5'h1F;
   localparam logic [4:0] SA_MODE_LO = 5'h00;
   localparam logic [4:0] SA_MODE_HI = 5'h1F;
   localparam int INFO_BROADCAST_FLAG_BIT = 9;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_PEND = 8'h09;
   localparam logic [7:0] IDX_IRQ_EN = 8'h12;
   localparam logic [7:0] IDX_CFG = 8'h17;
   localparam logic [7:0] IDX_EXT_CFG = 8'h4D;
   localparam logic [7:0] IDX_DESC_BASE = 8'h60;
   localparam logic [7:0] IDX_STATUS = 8'h61;
   localparam int PEND_WRAP_BIT = 0;
   localparam int CFG_BROADCAST_FLAG_SEP_BIT = 0;
   localparam int EXT_BROADCAST_FLAG_FLAG_BIT = 3;
   localparam logic [15:0] REG_RESET = 16'h0000;

   typedef struct packed {
      logic [4:0] rt_addr;
      logic tr;
      logic [4:0] subaddr;
      logic [4:0] wcount;
   } cbm_cmd_t;

   typedef struct packed {
      cbm_cmd_t cmd;
      logic busy;
      logic illegal;
   } cbm_start_t;

   typedef struct packed {
      logic [DATA_W-1:0] info;
      logic [DATA_W-1:0] ttag;
      logic error;
   } cbm_done_t;

   typedef enum logic [3:0] {
      CBM_IDLE = 4'h0,
      CBM_RD_CTL = 4'h1,
      CBM_RD_START = 4'h2,
      CBM_RD_CUR = 4'h3,
      CBM_RD_END = 4'h4,
      CBM_MSG = 4'h5,
      CBM_WR_DATA = 4'h6,
      CBM_RD_DATA = 4'h7,
      CBM_WR_INFO = 4'h8,
      CBM_WR_TTAG = 4'h9,
      CBM_WR_CUR = 4'hA
   } cbm_state_t;
endpackage

// ### core/cbm_ptr_next.sv
// Post-message current pointer choice with wrap to the start pointer.
`timescale 1ns/10ps
module cbm_ptr_next
   import cbm_pkg::*;
#(
   parameter int AW = RAM_AW
) (
   input wire logic [AW-1:0] last_plus_one, // Address after last data word.
   input wire logic [AW-1:0] start_pointer, // Descriptor start pointer.
   input wire logic [AW-1:0] end_pointer, // Descriptor end pointer.
   output logic [AW-1:0] next_current, // Value to write back.
   output logic wrap // Start pointer taken.
);
   initial begin
      if (AW < 4 || AW > DATA_W) $error("cbm_ptr_next: AW out of range");
   end
   // Unsigned; overrun past the end is allowed mid-message.
   assign wrap = last_plus_one > end_pointer;
   assign next_current = wrap ? start_pointer : last_plus_one;
endmodule

// ### core/cbm_apb_regs.sv
// APB register file and host interrupt for the circular buffer engine.
`timescale 1ns/10ps
module cbm_apb_regs
   import cbm_pkg::*;
(
   input wire logic pclk, // Bus clock.
   input wire logic presetn, // Reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [15:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error.
   input wire logic wrap_evt, // Wrap event pulse.
   input wire logic [15:0] status, // Engine status word.
   output logic [15:0] desc_base, // Descriptor base.
   output logic broadcast_flag_flag_en, // Broadcast flag enable.
   output logic int_n // Host interrupt, active low.
);
   logic [15:0] pend;
   logic [15:0] irq_en;
   logic [15:0] cfg;
   logic [15:0] ext_cfg;
   wire access = psel && penable && !pready;
   wire commit = psel && penable && pready;
   wire [7:0] idx = paddr[9:2];
   wire aligned = (paddr[1:0] == 2'h0) && (paddr[15:10] == 6'h00);
   wire hit_pend = aligned && idx == IDX_PEND;
   wire hit_en = aligned && idx == IDX_IRQ_EN;
   wire hit_cfg = aligned && idx == IDX_CFG;
   wire hit_ext = aligned && idx == IDX_EXT_CFG;
   wire hit_base = aligned && idx == IDX_DESC_BASE;
   wire hit_stat = aligned && idx == IDX_STATUS;
   wire mapped = hit_pend || hit_en || hit_cfg || hit_ext || hit_base || hit_stat;
   wire [15:0] rd_mux = hit_pend ? pend : hit_en ? irq_en : hit_cfg ? cfg :
      hit_ext ? ext_cfg : hit_base ? desc_base : hit_stat ? status : 16'h0000;
   wire wr = commit && pwrite;
   wire [15:0] set_bits = 16'(wrap_evt) << PEND_WRAP_BIT;
   // A wrap in the clearing cycle wins.
   wire [15:0] clr_bits = (wr && hit_pend) ? pwdata[15:0] : 16'h0000;
   wire [15:0] next_pend = (pend & ~clr_bits) | set_bits;

   ////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access && !mapped;
         prdata <= (access && !pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= REG_RESET;
         irq_en <= REG_RESET;
         cfg <= REG_RESET;
         ext_cfg <= REG_RESET;
         desc_base <= REG_RESET;
         int_n <= 1'b1;
      end else begin
         pend <= next_pend;
         if (wr && hit_en) irq_en <= pwdata[15:0];
         if (wr && hit_cfg) cfg <= pwdata[15:0];
         if (wr && hit_ext) ext_cfg <= pwdata[15:0];
         if (wr && hit_base) desc_base <= pwdata[15:0];
         int_n <= ~|(next_pend & irq_en);
      end
   end

   // The separation bit has no effect here.
   assign broadcast_flag_flag_en = ext_cfg[EXT_BROADCAST_FLAG_FLAG_BIT];
endmodule

// ### core/cbm_circ_buf.sv
// Circular buffer mode one engine for remote terminal subaddress storage.
// Operation
// - Only if pingpong and second-circular are 0, first-circular 1.
// - Mode codes never use circular handling.
// - Descriptor: control N, start N+1, current N+2, end N+3.
// - Descriptor picked by direction and subaddress.
// - Receive: info at current, time-tag next, data from current+2.
// - Receive data stored on arrival; info words after completion.
// - Transmit data fetched from current+2; info words after.
// - Clean message: current becomes next address, or start if past end.
// - Start and end pointers never written.
// - No wrap mid-message; decided at completion.
// - Error, busy or illegal: info words written, pointer kept; no data stored once refused or after msg_err.
// - Wrap drives low interrupt if descriptor and enable bits set.
// - Broadcast and normal receive data share one buffer.
// - Extended config bit 3 enables the info word broadcast flag.
// - Broadcast transmit to address 31: info words written, pointer kept.
// - Wrap interrupt select is control bit 15; event kept pending.
`timescale 1ns/10ps
module cbm_circ_buf
   import cbm_pkg::*;
#(
   parameter int AW = RAM_AW
) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [15:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error.
   input wire logic msg_start, // Command decoded pulse.
   input wire cbm_start_t start_info, // Command and flags.
   output logic msg_ready, // Engine takes input now.
   input wire logic rx_valid, // Receive word offered.
   input wire logic [15:0] rx_word, // Received data word.
   input wire logic msg_err, // Message error.
   input wire logic tx_req, // Next transmit word wanted.
   output logic [15:0] tx_word, // Fetched transmit word.
   output logic tx_valid, // Transmit word valid.
   input wire logic msg_done, // Message finished.
   input wire cbm_done_t done_info, // Completion words.
   output logic circ_active, // Descriptor selects this mode.
   output logic proc_done, // Handling finished.
   output logic ram_req, // RAM request.
   output logic ram_we, // RAM write.
   output logic [AW-1:0] ram_addr, // RAM word address.
   output logic [15:0] ram_wdata, // RAM write data.
   input wire logic [15:0] ram_rdata, // RAM read data.
   input wire logic ram_ack, // RAM acknowledge.
   output logic int_n // Host interrupt, active low.
);
   initial begin
      if (AW < 4 || AW > DATA_W) $error("cbm_circ_buf: AW out of range");
   end

   cbm_state_t state, next_state;
   logic [15:0] ctl, next_ctl;
   logic [AW-1:0] start_pointer, next_start;
   logic [AW-1:0] current_pointer, next_current_ptr;
   logic [AW-1:0] end_pointer, next_end;
   logic [AW-1:0] ptr, next_ptr;
   logic [AW-1:0] desc_addr, next_desc_addr;
   logic tr, next_tr;
   logic broadcast_flag, next_broadcast_flag;
   logic drop, next_drop;
   logic fail, next_fail;
   logic [15:0] ttag, next_ttag;
   logic next_req, next_we, next_active, next_done, next_tx_valid, next_wrap;
   logic [AW-1:0] next_addr;
   logic [15:0] next_wdata, next_tx_word;
   logic wrap_evt;
   logic [15:0] desc_base;
   logic broadcast_flag_flag_en;
   logic [AW-1:0] wb_current;
   logic wrap;

   ////////////////////////////////////////////////////////////
   cbm_apb_regs u_regs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .wrap_evt(wrap_evt),
      .status({11'h000, circ_active, state}),
      .desc_base(desc_base),
      .broadcast_flag_flag_en(broadcast_flag_flag_en),
      .int_n(int_n)
   );

   cbm_ptr_next #(.AW(AW)) u_ptr (
      .last_plus_one(ptr),
      .start_pointer(start_pointer),
      .end_pointer(end_pointer),
      .next_current(wb_current),
      .wrap(wrap)
   );

   ////////////////////////////////////////////////////////////
   wire cbm_cmd_t cmd = start_info.cmd;
   wire mode_code = (cmd.subaddr == SA_MODE_LO) || (cmd.subaddr == SA_MODE_HI);
   wire [AW-1:0] base = desc_base[AW-1:0];
   wire [AW-1:0] cmd_desc = base + AW'({cmd.tr, cmd.subaddr, 2'h0});
   wire mode_one = !ctl[CTL_PINGPONG_BIT] && !ctl[CTL_CIRC2_BIT] && ctl[CTL_CIRC1_BIT];
   wire [15:0] rd_word = ram_rdata;
   wire acked = ram_req && ram_ack;
   wire broadcast_flag_tx = tr && broadcast_flag;
   wire [AW-1:0] cur_desc = desc_addr + AW'(DESC_CUR);
   wire [15:0] info_word = broadcast_flag_flag_en ?
      ((done_info.info & ~(16'h0001 << INFO_BROADCAST_FLAG_BIT)) |
       (16'(broadcast_flag) << INFO_BROADCAST_FLAG_BIT)) : done_info.info;

   always_comb begin
      next_state = state;
      next_ctl = ctl;
      next_start = start_pointer;
      next_current_ptr = current_pointer;
      next_end = end_pointer;
      next_ptr = ptr;
      next_desc_addr = desc_addr;
      next_tr = tr;
      next_broadcast_flag = broadcast_flag;
      next_drop = drop;
      next_fail = fail;
      next_ttag = ttag;
      next_req = ram_req && !ram_ack;
      next_we = ram_we;
      next_addr = ram_addr;
      next_wdata = ram_wdata;
      next_active = circ_active;
      next_done = 1'b0;
      next_tx_valid = 1'b0;
      next_tx_word = tx_word;
      next_wrap = 1'b0;
      case (state)
         CBM_IDLE: begin
            if (msg_start) begin
               next_tr = cmd.tr;
               next_broadcast_flag = (cmd.rt_addr == BROADCAST_FLAG_RT);
               next_drop = start_info.busy || start_info.illegal;
               next_desc_addr = cmd_desc;
               if (mode_code) begin
                  next_active = 1'b0;
                  next_done = 1'b1;
               end else begin
                  next_req = 1'b1;
                  next_we = 1'b0;
                  next_addr = cmd_desc + AW'(DESC_CTL);
                  next_state = CBM_RD_CTL;
               end
            end
         end
         CBM_RD_CTL: begin
            if (acked) begin
               next_ctl = rd_word;
               next_req = 1'b1;
               next_addr = desc_addr + AW'(DESC_START);
               next_state = CBM_RD_START;
            end
         end
         CBM_RD_START: begin
            if (acked) begin
               next_start = rd_word[AW-1:0];
               next_req = 1'b1;
               next_addr = cur_desc;
               next_state = CBM_RD_CUR;
            end
         end
         CBM_RD_CUR: begin
            if (acked) begin
               next_current_ptr = rd_word[AW-1:0];
               next_ptr = rd_word[AW-1:0] + AW'(REC_DATA_OFS);
               next_req = 1'b1;
               next_addr = desc_addr + AW'(DESC_END);
               next_state = CBM_RD_END;
            end
         end
         CBM_RD_END: begin
            if (acked) begin
               next_end = rd_word[AW-1:0];
               next_active = mode_one;
               next_done = !mode_one;
               next_state = mode_one ? CBM_MSG : CBM_IDLE;
            end
         end
         CBM_MSG: begin
            if (msg_done) begin
               next_fail = drop || msg_err || done_info.error;
               next_ttag = done_info.ttag;
               next_req = 1'b1;
               next_we = 1'b1;
               next_addr = current_pointer;
               next_wdata = info_word;
               next_state = CBM_WR_INFO;
            end else if (rx_valid) begin
               // Words after an error or a refused command are dropped.
               if (msg_err) next_drop = 1'b1;
               if (!drop && !msg_err) begin
                  next_req = 1'b1;
                  next_we = 1'b1;
                  next_addr = ptr;
                  next_wdata = rx_word;
                  next_ptr = ptr + AW'(1);
                  next_state = CBM_WR_DATA;
               end
            end else if (tx_req) begin
               next_req = 1'b1;
               next_we = 1'b0;
               next_addr = ptr;
               next_ptr = ptr + AW'(1);
               next_state = CBM_RD_DATA;
            end
         end
         CBM_WR_DATA: begin
            if (acked) next_state = CBM_MSG;
         end
         CBM_RD_DATA: begin
            if (acked) begin
               next_tx_word = rd_word;
               next_tx_valid = 1'b1;
               next_state = CBM_MSG;
            end
         end
         CBM_WR_INFO: begin
            if (acked) begin
               next_req = 1'b1;
               next_addr = current_pointer + AW'(REC_TTAG_OFS);
               next_wdata = ttag;
               next_state = CBM_WR_TTAG;
            end
         end
         CBM_WR_TTAG: begin
            if (acked) begin
               if (fail || broadcast_flag_tx) begin
                  next_done = 1'b1;
                  next_state = CBM_IDLE;
               end else begin
                  next_req = 1'b1;
                  next_addr = cur_desc;
                  next_wdata = 16'(wb_current);
                  next_state = CBM_WR_CUR;
               end
            end
         end
         CBM_WR_CUR: begin
            if (acked) begin
               next_wrap = wrap && ctl[CTL_WRAP_IRQ_BIT];
               next_done = 1'b1;
               next_state = CBM_IDLE;
            end
         end
         default: next_state = CBM_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= CBM_IDLE;
         ctl <= 16'h0000;
         start_pointer <= '0;
         current_pointer <= '0;
         end_pointer <= '0;
         ptr <= '0;
         desc_addr <= '0;
         tr <= 1'b0;
         broadcast_flag <= 1'b0;
         drop <= 1'b0;
         fail <= 1'b0;
         ttag <= 16'h0000;
      end else begin
         state <= next_state;
         ctl <= next_ctl;
         start_pointer <= next_start;
         current_pointer <= next_current_ptr;
         end_pointer <= next_end;
         ptr <= next_ptr;
         desc_addr <= next_desc_addr;
         tr <= next_tr;
         broadcast_flag <= next_broadcast_flag;
         drop <= next_drop;
         fail <= next_fail;
         ttag <= next_ttag;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ram_req <= 1'b0;
         ram_we <= 1'b0;
         ram_addr <= '0;
         ram_wdata <= 16'h0000;
         circ_active <= 1'b0;
         proc_done <= 1'b0;
         tx_word <= 16'h0000;
         tx_valid <= 1'b0;
         wrap_evt <= 1'b0;
         msg_ready <= 1'b0;
      end else begin
         ram_req <= next_req;
         ram_we <= next_we;
         ram_addr <= next_addr;
         ram_wdata <= next_wdata;
         circ_active <= next_active;
         proc_done <= next_done;
         tx_word <= next_tx_word;
         tx_valid <= next_tx_valid;
         wrap_evt <= next_wrap;
         msg_ready <= (next_state == CBM_MSG);
      end
   end
endmodule

// ### tb/cbm_ram_model.sv
// Shared RAM model that answers promptly or with wait cycles.
`timescale 1ns/10ps
module cbm_ram_model
   import cbm_pkg::*;
(
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic slow, // Adds wait cycles.
   input wire logic ram_req, // Request.
   input wire logic ram_we, // Write.
   input wire logic [RAM_AW-1:0] ram_addr, // Word address.
   input wire logic [15:0] ram_wdata, // Write data.
   output logic [15:0] ram_rdata, // Read data.
   output logic ram_ack // Acknowledge.
);
   logic [15:0] mem [0:(1<<RAM_AW)-1];
   logic [1:0] cnt;
   // Read data toggles outside an acknowledge.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ram_ack <= 1'b0;
         cnt <= 2'h0;
         ram_rdata <= 16'h0000;
      end else if (ram_req && !ram_ack && (!slow || cnt == 2'h3)) begin
         ram_ack <= 1'b1;
         cnt <= 2'h0;
         if (ram_we) begin
            mem[ram_addr] <= ram_wdata;
         end else begin
            ram_rdata <= mem[ram_addr];
         end
      end else begin
         ram_ack <= 1'b0;
         ram_rdata <= ~ram_rdata;
         cnt <= (ram_req && !ram_ack) ? cnt + 2'h1 : 2'h0;
      end
   end
endmodule

// ### tb/cbm_monitor.sv
// Concurrent checks on the ports of the circular buffer engine.
`timescale 1ns/10ps
module cbm_monitor
   import cbm_pkg::*;
#(
   parameter int AW = RAM_AW
) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset.
   input wire logic psel, // In.
   input wire logic penable, // In.
   input wire logic [31:0] prdata, // Out.
   input wire logic pready, // Out.
   input wire logic pslverr, // Out.
   input wire logic msg_start, // In.
   input wire cbm_start_t start_info, // In.
   input wire logic msg_ready, // Out.
   input wire logic rx_valid, // In.
   input wire logic msg_err, // In.
   input wire logic msg_done, // In.
   input wire logic tx_valid, // Out.
   input wire logic circ_active, // Out.
   input wire logic proc_done, // Out.
   input wire logic ram_req, // Out.
   input wire logic ram_we, // Out.
   input wire logic [AW-1:0] ram_addr, // Out.
   input wire logic [15:0] ram_wdata, // Out.
   input wire logic ram_ack // In.
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire mode_sa = start_info.cmd.subaddr == SA_MODE_LO || start_info.cmd.subaddr == SA_MODE_HI;
   wire good = !start_info.busy && !start_info.illegal && circ_active;
   ////////////////////////////////////////////////////////////
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable; endsequence
   sequence s_rx_take; rx_valid && msg_ready && !msg_done && !msg_err && good; endsequence
   property p_apb_wait; s_setup ##1 s_access |=> pready; endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("pready late");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
   property p_err_ready; pslverr |-> pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
   property p_rdata_idle; !pready |-> prdata == 32'h00000000; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
   property p_ram_hold;
      ram_req && !ram_ack |=> ram_req && $stable(ram_addr) && $stable(ram_we) && $stable(ram_wdata);
   endproperty
   a_ram_hold: assert property (p_ram_hold) else $error("ram request dropped");
   property p_desc_read; msg_start && !mode_sa |=> ram_req && !ram_we; endproperty
   a_desc_read: assert property (p_desc_read) else $error("no descriptor read");
   property p_mode_code; msg_start && mode_sa |=> proc_done && !ram_req; endproperty
   a_mode_code: assert property (p_mode_code) else $error("mode code handled");
   property p_rx_store; s_rx_take |=> ##[0:3] ram_req && ram_we; endproperty
   a_rx_store: assert property (p_rx_store) else $error("rx word not stored");
   property p_tx_fetch; tx_valid |-> $past(ram_ack) && !$past(ram_we) ##1 !tx_valid; endproperty
   a_tx_fetch: assert property (p_tx_fetch) else $error("tx word not fetched");
endmodule
bind cbm_circ_buf cbm_monitor #(.AW(AW)) mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .msg_start(msg_start), .start_info(start_info), .msg_ready(msg_ready), .rx_valid(rx_valid),
   .msg_err(msg_err), .msg_done(msg_done), .tx_valid(tx_valid), .circ_active(circ_active),
   .proc_done(proc_done), .ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr),
   .ram_wdata(ram_wdata), .ram_ack(ram_ack));

// ### tb/tb_cbm_circ_buf.sv
// Self-checking bench for the circular buffer mode one engine.
`timescale 1ns/10ps
module tb_cbm_circ_buf
   import cbm_pkg::*;
();
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000, rx_word = 16'h0000;
   logic [31:0] pwdata = 32'h00000000, prdata, r;
   logic pready, pslverr, msg_ready, tx_valid, circ_active, proc_done, ram_req, ram_we, ram_ack;
   logic msg_start = 1'b0, rx_valid = 1'b0, msg_err = 1'b0, tx_req = 1'b0, msg_done = 1'b0;
   logic slow = 1'b0, bfl = 1'b0, int_n, e, act;
   logic [15:0] tx_word, ram_wdata, ram_rdata;
   logic [RAM_AW-1:0] ram_addr;
   cbm_start_t start_info = '0;
   cbm_done_t done_info = '0;
   int fail_count = 0, checks = 0, i;
   always #5 pclk = ~pclk;
   cbm_circ_buf dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .msg_start(msg_start), .start_info(start_info), .msg_ready(msg_ready),
      .rx_valid(rx_valid), .rx_word(rx_word), .msg_err(msg_err), .tx_req(tx_req),
      .tx_word(tx_word), .tx_valid(tx_valid), .msg_done(msg_done), .done_info(done_info),
      .circ_active(circ_active), .proc_done(proc_done), .ram_req(ram_req), .ram_we(ram_we),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ram_ack(ram_ack),
      .int_n(int_n));
   cbm_ram_model ram_u (.pclk(pclk), .presetn(presetn), .slow(slow), .ram_req(ram_req),
      .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
      .ram_ack(ram_ack));
   ////////////////////////////////////////////////////////////
   task automatic close_out();
      if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wt(ref logic s, input logic v);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (s !== v && n < 100);
      if (s !== v) begin
         fail_count++;
         close_out();
      end
   endtask
   task automatic apb(input logic w, logic [7:0] idx, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {6'h00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      wt(pready, 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One message from the protocol engine side.
   task automatic msg(input logic [4:0] rt, logic tr, logic [4:0] sa, int n,
      logic [2:0] fl, logic [RAM_AW-1:0] ca, nc);
      logic [RAM_AW-1:0] nd;
      logic [15:0] s0, e0, inf, tt;
      int k;
      nd = 13'h0100 + {5'h00, tr, sa, 2'b00};
      s0 = ram_u.mem[nd+1];
      e0 = ram_u.mem[nd+3];
      inf = 16'h0040 + 16'(n);
      tt = ~inf;
      for (k = 0; k < n + 2; k++) ram_u.mem[ca+k] = (tr && k > 1) ? 16'hA4FE + 16'(k) : 16'hDEAD;
      @(posedge pclk);
      start_info <= '{'{rt, tr, sa, n[4:0]}, fl[1], fl[2]};
      msg_start <= 1'b1;
      msg_err <= fl[0];
      @(posedge pclk);
      msg_start <= 1'b0;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (msg_ready !== 1'b1 && proc_done !== 1'b1 && k < 50);
      act = circ_active;
      if (msg_ready !== 1'b1) begin
         if (proc_done !== 1'b1) wt(proc_done, 1'b1);
         chk(ram_u.mem[ca], 16'hDEAD);
         msg_err <= 1'b0;
         return;
      end
      for (k = 0; k < n && !(tr && rt == BROADCAST_FLAG_RT); k++) begin
         @(posedge pclk);
         if (tr) begin
            tx_req <= 1'b1;
            wt(msg_ready, 1'b1);
            tx_req <= 1'b0;
            wt(tx_valid, 1'b1);
            chk(tx_word, 16'hA500 + 16'(k));
         end else begin
            rx_valid <= 1'b1;
            rx_word <= 16'h5A00 + 16'(k);
            wt(msg_ready, 1'b1);
            rx_valid <= 1'b0;
         end
      end
      chk(ram_u.mem[ca], 16'hDEAD);
      @(posedge pclk);
      msg_done <= 1'b1;
      done_info <= '{inf, tt, fl[0]};
      wt(msg_ready, 1'b1);
      msg_done <= 1'b0;
      wt(proc_done, 1'b1);
      msg_err <= 1'b0;
      inf[INFO_BROADCAST_FLAG_BIT] = rt == BROADCAST_FLAG_RT && bfl;
      chk(ram_u.mem[ca], inf);
      chk(ram_u.mem[ca+1], tt);
      for (k = 0; k < n && !tr; k++) begin
         chk(ram_u.mem[ca+2+k], fl == 3'h0 ? 16'h5A00 + 16'(k) : 16'hDEAD);
      end
      chk(ram_u.mem[nd+2], nc);
      chk(ram_u.mem[nd+1], s0);
      chk(ram_u.mem[nd+3], e0);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      for (i = 0; i < (1 << RAM_AW); i++) ram_u.mem[i] = 16'hDEAD;
      ram_u.mem[13'h104] = 16'h8002;
      ram_u.mem[13'h105] = 16'h0200;
      ram_u.mem[13'h106] = 16'h0200;
      ram_u.mem[13'h107] = 16'h0205;
      ram_u.mem[13'h188] = 16'h0002;
      ram_u.mem[13'h189] = 16'h0300;
      ram_u.mem[13'h18A] = 16'h0300;
      ram_u.mem[13'h18B] = 16'h03FF;
      ram_u.mem[13'h10C] = 16'h0003;
      ram_u.mem[13'h110] = 16'h0006;
      ram_u.mem[13'h114] = 16'h0000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(int_n, 1'b1);
      apb(1'b1, IDX_DESC_BASE, 32'h00000100);
      apb(1'b1, IDX_IRQ_EN, 32'h00000001);
      apb(1'b1, IDX_CFG, 32'h00000001);
      apb(1'b0, IDX_IRQ_EN, 32'h00000000);
      chk(r, 32'h00000001);
      apb(1'b0, 8'hFF, 32'h00000000);
      chk({e, r}, {1'b1, 32'h00000000});
      msg(5'h01, 1'b0, 5'h01, 3, 3'h0, 13'h0200, 13'h0205);
      chk(int_n, 1'b1);
      bfl = 1'b1;
      apb(1'b1, IDX_EXT_CFG, 32'h00000008);
      msg(BROADCAST_FLAG_RT, 1'b0, 5'h01, 2, 3'h0, 13'h0205, 13'h0200);
      wt(int_n, 1'b0);
      apb(1'b0, IDX_PEND, 32'h00000000);
      chk(r, 32'h00000001);
      apb(1'b1, IDX_PEND, 32'h00000001);
      wt(int_n, 1'b1);
      for (i = 0; i < 3; i++) msg(5'h01, 1'b0, 5'h01, 2, 3'(1 << i), 13'h0200, 13'h0200);
      slow = 1'b1;
      msg(5'h01, 1'b1, 5'h02, 2, 3'h0, 13'h0300, 13'h0304);
      msg(BROADCAST_FLAG_RT, 1'b1, 5'h02, 2, 3'h0, 13'h0304, 13'h0304);
      slow = 1'b0;
      for (i = 0; i < 2; i++) begin
         msg(5'h01, 1'b0, i ? SA_MODE_HI : SA_MODE_LO, 1, 3'h0, 13'h0400, 13'h0400);
         chk(act, 1'b0);
      end
      for (i = 3; i < 6; i++) begin
         msg(5'h01, 1'b0, 5'(i), 1, 3'h0, 13'h0400, 13'h0400);
         chk(act, 1'b0);
      end
      chk(int_n, 1'b1);
      close_out();
   end
endmodule
